// ===== hdl/cdcfg_bank.sv
// Behaviour
// - Sidetone code 000..110: -3 to -21 dB
// - Sidetone code 111 mutes; reset value
// - Buffer gain 11/10/01: 24/12/6 dB
// - Buffer gain 00 is 0 dB; reset
// - Output style bit D7, resets 0
// - Style 0: differential, shared inverting node
// - Style 1: both outputs single-ended
// - Common node: ground or shared inverting
// - D6 mutes first output; resets 0
// - D5 mutes second output; resets 0
// - Driver field resets 00; all off
// - Driver 01: first on only
// - Driver 10: second on only
// - Driver 11 behaves as 10
// - Input select resets 00; first pair
// - Select 01: mic, internal bias
// - Select 10: mic, external common mode
// - Select 11: second differential pair
// - Register 5 reads cycle four values
`timescale 1ns/1ps
`default_nettype none
`include "cdcfg_map.svh"

module cdcfg_bank
    import cdcfg_pkg::*;
#(
    parameter logic [5:0] VERSION_ID = 6'h15  // Arbitrary value
)
(
    input wire logic mclk_i,                          // 25 MHz clock
    input wire logic resetn_i,                        // Async reset, active low
    input wire logic [`CDCFG_ADDR_W-1:0] addr_i,      // Register address
    input wire logic [7:0] wdata_i,                   // Write data
    input wire logic wr_i,                            // Write strobe
    input wire logic rd_i,                            // Read strobe
    output logic [7:0] rdata_o,                       // Read data, next cycle
    input wire logic [7:0] adc_gain_i,                // ADC gain byte
    input wire logic [7:0] dac_gain_i,                // DAC gain byte
    output logic [4:0] sidetone_atten_db_o,           // Sidetone attenuation
    output logic [4:0] inbuf_gain_db_o,               // Input buffer gain
    output logic sidetone_mute_o,                     // Sidetone muted
    output logic single_ended_o,                      // Outputs single-ended
    output logic common_vground_o,                    // Common node is ground
    output logic common_inverting_o,                  // Common node inverts
    output logic first_drive_o,                       // First driver on
    output logic second_drive_o,                      // Second driver on
    output logic first_mute_o,                        // First output muted
    output logic second_mute_o,                       // Second output muted
    output logic [3:0] adc_route_o,                   // One-hot ADC source
    output logic mic_self_bias_o,                     // Mic internal bias
    output logic mic_ext_cm_o                         // Mic external bias
);

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    function automatic logic [4:0] stg_db(input logic [2:0] code);
        stg_db = `CDCFG_STG_MIN_DB + ({2'h0, code} * `CDCFG_STG_STEP_DB);
    endfunction : stg_db

    function automatic logic [4:0] input_buffer_gain_code_db(input logic [1:0] code);
        case (code)
            2'h1: input_buffer_gain_code_db = `CDCFG_INPUT_BUFFER_GAIN_CODE_DB_01;
            2'h2: input_buffer_gain_code_db = `CDCFG_INPUT_BUFFER_GAIN_CODE_DB_10;
            2'h3: input_buffer_gain_code_db = `CDCFG_INPUT_BUFFER_GAIN_CODE_DB_11;
            default: input_buffer_gain_code_db = `CDCFG_INPUT_BUFFER_GAIN_CODE_DB_00;
        endcase
    endfunction : input_buffer_gain_code_db

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    logic [2:0] sidetone_gain_code;
    logic [1:0] input_buffer_gain_code;
    logic [7:0] output_and_input_routing;
    cdcfg_rdseq_t rdseq;
    cdcfg_rdseq_t next_rdseq;

    cdcfg_ctl_if ctl ();

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    wire hit5 = (addr_i == `CDCFG_REG5_ADDR);
    wire hit6 = (addr_i == `CDCFG_REG6_ADDR);
    wire [1:0] wsel = wdata_i[`CDCFG_SEL_HI:`CDCFG_SEL_LO];
    wire wr_5c = wr_i && hit5 && (wsel == `CDCFG_SEL_5C);
    wire wr_6 = wr_i && hit6;
    wire rd_5 = rd_i && hit5;

    // ----------------------------------------
    // Readback images
    // ----------------------------------------
    // D2 reads zero
    wire [7:0] img_5c = {`CDCFG_SEL_5C, sidetone_gain_code, 1'b0, input_buffer_gain_code};
    wire [7:0] img_5d = {`CDCFG_SEL_5D, VERSION_ID};

    logic [7:0] img_5;
    always_comb
    begin
        case (rdseq)
            CDCFG_RD_ADC: img_5 = adc_gain_i;
            CDCFG_RD_DAC: img_5 = dac_gain_i;
            CDCFG_RD_SIDE: img_5 = img_5c;
            CDCFG_RD_VER: img_5 = img_5d;
            default: img_5 = 8'h00;
        endcase
    end

    wire [7:0] rd_byte = hit5 ? img_5 : (hit6 ? output_and_input_routing : 8'h00);

    // ----------------------------------------
    // Read sequence
    // ----------------------------------------
    always_comb
    begin
        next_rdseq = rdseq;
        if (rd_5)
        begin
            case (rdseq)
                CDCFG_RD_ADC: next_rdseq = CDCFG_RD_DAC;
                CDCFG_RD_DAC: next_rdseq = CDCFG_RD_SIDE;
                CDCFG_RD_SIDE: next_rdseq = CDCFG_RD_VER;
                CDCFG_RD_VER: next_rdseq = CDCFG_RD_ADC;
                default: next_rdseq = CDCFG_RD_ADC;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rdseq <= CDCFG_RD_ADC;
        end
        else
        begin
            rdseq <= next_rdseq;
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rdata_o <= 8'h00;
        end
        else if (rd_i)
        begin
            rdata_o <= rd_byte;
        end
        else
        begin
            rdata_o <= 8'h00;
        end
    end

    // ----------------------------------------
    // Subregister 5C
    // ----------------------------------------
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            sidetone_gain_code <= `CDCFG_STG_MUTE;
            input_buffer_gain_code <= `CDCFG_INPUT_BUFFER_GAIN_CODE_RESET;
        end
        else if (wr_5c)
        begin
            sidetone_gain_code <= wdata_i[`CDCFG_STG_HI:`CDCFG_STG_LO];
            input_buffer_gain_code <= wdata_i[`CDCFG_INPUT_BUFFER_GAIN_CODE_HI:`CDCFG_INPUT_BUFFER_GAIN_CODE_LO];
        end
    end

    // ----------------------------------------
    // Register 6
    // ----------------------------------------
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            output_and_input_routing <= `CDCFG_REG6_RESET;
        end
        else if (wr_6)
        begin
            output_and_input_routing <= wdata_i;
        end
    end

    // ----------------------------------------
    // Field fan-out
    // ----------------------------------------
    assign ctl.sidetone_gain_code = sidetone_gain_code;
    assign ctl.output_style_select = output_and_input_routing[`CDCFG_STYLE_BIT];
    assign ctl.first_output_mute = output_and_input_routing[`CDCFG_MUTE1_BIT];
    assign ctl.second_output_mute = output_and_input_routing[`CDCFG_FIRST_OUTPUT_MUTE_BIT];
    assign ctl.output_driver_enables = output_and_input_routing[`CDCFG_DRV_HI:`CDCFG_DRV_LO];
    assign ctl.adc_input_select = output_and_input_routing[`CDCFG_AIN_HI:`CDCFG_AIN_LO];

    // ----------------------------------------
    // Gain figures
    // ----------------------------------------
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            sidetone_atten_db_o <= 5'h00;
            inbuf_gain_db_o <= `CDCFG_INPUT_BUFFER_GAIN_CODE_DB_00;
        end
        else
        begin
            // 3 dB steps, zero while muted
            sidetone_atten_db_o <= (sidetone_gain_code == `CDCFG_STG_MUTE) ? 5'h00 : stg_db(sidetone_gain_code);
            inbuf_gain_db_o <= input_buffer_gain_code_db(input_buffer_gain_code);
        end
    end

    // ----------------------------------------
    // Analog control decode
    // ----------------------------------------
    cdcfg_outdec u_outdec
    (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .ctl(ctl.dec),
        .sidetone_mute_o(sidetone_mute_o),
        .single_ended_o(single_ended_o),
        .common_vground_o(common_vground_o),
        .common_inverting_o(common_inverting_o),
        .first_drive_o(first_drive_o),
        .second_drive_o(second_drive_o),
        .first_mute_o(first_mute_o),
        .second_mute_o(second_mute_o),
        .adc_route_o(adc_route_o),
        .mic_self_bias_o(mic_self_bias_o),
        .mic_ext_cm_o(mic_ext_cm_o)
    );

endmodule : cdcfg_bank

`default_nettype wire

// ===== hdl/cdcfg_ctl_if.sv
`timescale 1ns/1ps
`default_nettype none

interface cdcfg_ctl_if;
    logic [2:0] sidetone_gain_code;
    logic output_style_select;
    logic first_output_mute;
    logic second_output_mute;
    logic [1:0] output_driver_enables;
    logic [1:0] adc_input_select;

    modport bank
    (
        output sidetone_gain_code,
        output output_style_select,
        output first_output_mute,
        output second_output_mute,
        output output_driver_enables,
        output adc_input_select
    );

    modport dec
    (
        input sidetone_gain_code,
        input output_style_select,
        input first_output_mute,
        input second_output_mute,
        input output_driver_enables,
        input adc_input_select
    );
endinterface : cdcfg_ctl_if

`default_nettype wire

// ===== hdl/cdcfg_map.svh
`ifndef CDCFG_MAP_SVH
`define CDCFG_MAP_SVH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define CDCFG_ADDR_W 3
`define CDCFG_REG5_ADDR 3'h5
`define CDCFG_REG6_ADDR 3'h6

// ----------------------------------------
// Register 5 fields
// ----------------------------------------
`define CDCFG_SEL_HI 7
`define CDCFG_SEL_LO 6
`define CDCFG_SEL_5C 2'h2
`define CDCFG_SEL_5D 2'h3
`define CDCFG_STG_HI 5
`define CDCFG_STG_LO 3
`define CDCFG_INPUT_BUFFER_GAIN_CODE_HI 1
`define CDCFG_INPUT_BUFFER_GAIN_CODE_LO 0

// ----------------------------------------
// Register 6 fields
// ----------------------------------------
`define CDCFG_STYLE_BIT 7
`define CDCFG_MUTE1_BIT 6
`define CDCFG_FIRST_OUTPUT_MUTE_BIT 5
`define CDCFG_DRV_HI 4
`define CDCFG_DRV_LO 3
`define CDCFG_AIN_HI 2
`define CDCFG_AIN_LO 1
`define CDCFG_RSV6_BIT 0

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define CDCFG_STG_MUTE 3'h7
`define CDCFG_INPUT_BUFFER_GAIN_CODE_RESET 2'h0
`define CDCFG_REG6_RESET 8'h00
`define CDCFG_STG_MIN_DB 5'h03
`define CDCFG_STG_STEP_DB 5'h03
`define CDCFG_INPUT_BUFFER_GAIN_CODE_DB_00 5'h00
`define CDCFG_INPUT_BUFFER_GAIN_CODE_DB_01 5'h06
`define CDCFG_INPUT_BUFFER_GAIN_CODE_DB_10 5'h0C
`define CDCFG_INPUT_BUFFER_GAIN_CODE_DB_11 5'h18
`define CDCFG_DRV_FIRST 2'h1
`define CDCFG_DRV_SECOND 2'h2
`define CDCFG_DRV_BOTHCODE 2'h3
`define CDCFG_AIN_PAIR1 2'h0
`define CDCFG_AIN_MIC_INT 2'h1
`define CDCFG_AIN_MIC_EXT 2'h2
`define CDCFG_AIN_PAIR2 2'h3

`endif

// ===== hdl/cdcfg_outdec.sv
`timescale 1ns/1ps
`default_nettype none
`include "cdcfg_map.svh"

module cdcfg_outdec
    import cdcfg_pkg::*;
(
    input wire logic mclk_i,           // System clock
    input wire logic resetn_i,         // Async reset, active low
    cdcfg_ctl_if.dec ctl,              // Stored fields
    output logic sidetone_mute_o,      // Sidetone path muted
    output logic single_ended_o,       // Outputs single-ended
    output logic common_vground_o,     // Common node is virtual ground
    output logic common_inverting_o,   // Common node is inverting output
    output logic first_drive_o,        // First output driver on
    output logic second_drive_o,       // Second output driver on
    output logic first_mute_o,         // First output muted
    output logic second_mute_o,        // Second output muted
    output logic [3:0] adc_route_o,    // One-hot ADC source
    output logic mic_self_bias_o,      // Mic biased internally
    output logic mic_ext_cm_o          // Mic common mode on neg input
);

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    // Mute code
    wire st_mute = (ctl.sidetone_gain_code == `CDCFG_STG_MUTE);
    wire se = ctl.output_style_select;
    // Driver decode, 11 acts as 10
    wire drv1 = (ctl.output_driver_enables == `CDCFG_DRV_FIRST);
    wire drv2 = (ctl.output_driver_enables == `CDCFG_DRV_SECOND)
        || (ctl.output_driver_enables == `CDCFG_DRV_BOTHCODE);
    wire [3:0] route = 4'h1 << ctl.adc_input_select;

    // ----------------------------------------
    // Output registers
    // ----------------------------------------
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            sidetone_mute_o <= 1'h1;
            single_ended_o <= 1'h0;
            common_vground_o <= 1'h0;
            common_inverting_o <= 1'h1;
            first_drive_o <= 1'h0;
            second_drive_o <= 1'h0;
            first_mute_o <= 1'h0;
            second_mute_o <= 1'h0;
            adc_route_o <= 4'h1;
            mic_self_bias_o <= 1'h0;
            mic_ext_cm_o <= 1'h0;
        end
        else
        begin
            sidetone_mute_o <= st_mute;
            single_ended_o <= se;
            common_vground_o <= se;
            common_inverting_o <= !se;
            first_drive_o <= drv1;
            second_drive_o <= drv2;
            first_mute_o <= ctl.first_output_mute;
            second_mute_o <= ctl.second_output_mute;
            adc_route_o <= route;
            mic_self_bias_o <= (ctl.adc_input_select == `CDCFG_AIN_MIC_INT);
            mic_ext_cm_o <= (ctl.adc_input_select == `CDCFG_AIN_MIC_EXT);
        end
    end

endmodule : cdcfg_outdec

`default_nettype wire

// ===== hdl/cdcfg_pkg.sv
`default_nettype none

package cdcfg_pkg;

    // Register 5 read sequence position
    typedef enum logic [1:0]
    {
        CDCFG_RD_ADC,
        CDCFG_RD_DAC,
        CDCFG_RD_SIDE,
        CDCFG_RD_VER
    } cdcfg_rdseq_t;

endpackage : cdcfg_pkg

`default_nettype wire

// ===== test/cdcfg_bank_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "cdcfg_map.svh"

module cdcfg_bank_chk
(
    input wire logic mclk_i, // Clock
    input wire logic resetn_i, // Reset, active low
    input wire logic [`CDCFG_ADDR_W-1:0] addr_i, // Address
    input wire logic [7:0] wdata_i, // Write data
    input wire logic wr_i, // Write strobe
    input wire logic rd_i, // Read strobe
    input wire logic [7:0] rdata_o, // Read data
    input wire logic [4:0] sidetone_atten_db_o, // Attenuation
    input wire logic [4:0] inbuf_gain_db_o, // Buffer gain
    input wire logic sidetone_mute_o, // Sidetone muted
    input wire logic single_ended_o, // Style
    input wire logic common_vground_o, // Common ground
    input wire logic common_inverting_o, // Common inverting
    input wire logic first_drive_o, // First driver
    input wire logic second_drive_o, // Second driver
    input wire logic [3:0] adc_route_o, // ADC source
    input wire logic mic_self_bias_o, // Mic internal
    input wire logic mic_ext_cm_o // Mic external
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!resetn_i);

    sequence s_wr5c;
        wr_i && addr_i == `CDCFG_REG5_ADDR && wdata_i[7:6] == `CDCFG_SEL_5C;
    endsequence
    // Field stored at the write edge, figure registered one edge later
    property p_wr_atten;
        s_wr5c |-> ##2 sidetone_atten_db_o ==
            ($past(wdata_i[5:3], 2) == 3'h7 ? 5'h00 : 5'h03 * ($past(wdata_i[5:3], 2) + 5'h01));
    endproperty
    property p_wr_gain;
        s_wr5c |-> ##2 inbuf_gain_db_o ==
            ($past(wdata_i[1:0], 2) == 2'h3 ? 5'h18 : 5'h06 * $past(wdata_i[1:0], 2));
    endproperty
    // Mute flag and attenuation figure share one register stage
    property p_mute;
        sidetone_mute_o == (sidetone_atten_db_o == 5'h00);
    endproperty
    property p_common;
        common_vground_o == single_ended_o && common_inverting_o == !single_ended_o;
    endproperty
    property p_drive;
        !(first_drive_o && second_drive_o);
    endproperty
    property p_route;
        $onehot(adc_route_o) && mic_self_bias_o == adc_route_o[1] && mic_ext_cm_o == adc_route_o[2];
    endproperty
    property p_rd_idle;
        (!rd_i || (addr_i != `CDCFG_REG5_ADDR && addr_i != `CDCFG_REG6_ADDR)) |=> rdata_o == 8'h00;
    endproperty
    property p_steer;
        wr_i && addr_i == `CDCFG_REG5_ADDR && wdata_i[7:6] != `CDCFG_SEL_5C
            |-> ##2 $stable(sidetone_atten_db_o) && $stable(inbuf_gain_db_o);
    endproperty

    a_wr_atten: assert property (p_wr_atten) else $error("sidetone attenuation wrong");
    a_wr_gain: assert property (p_wr_gain) else $error("input buffer gain wrong");
    a_mute: assert property (p_mute) else $error("sidetone mute wrong");
    a_common: assert property (p_common) else $error("common node role wrong");
    a_drive: assert property (p_drive) else $error("both drivers on");
    a_route: assert property (p_route) else $error("adc route wrong");
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
    a_steer: assert property (p_steer) else $error("steered write stored");
endmodule : cdcfg_bank_chk

bind cdcfg_bank cdcfg_bank_chk u_chk
(
    .mclk_i,
    .resetn_i,
    .addr_i,
    .wdata_i,
    .wr_i,
    .rd_i,
    .rdata_o,
    .sidetone_atten_db_o,
    .inbuf_gain_db_o,
    .sidetone_mute_o,
    .single_ended_o,
    .common_vground_o,
    .common_inverting_o,
    .first_drive_o,
    .second_drive_o,
    .adc_route_o,
    .mic_self_bias_o,
    .mic_ext_cm_o
);

`default_nettype wire

// ===== test/test_codec_sidetone_output_input_config.sv
`timescale 1ns/1ps
`default_nettype none
`include "cdcfg_map.svh"

module test_codec_sidetone_output_input_config;
    typedef struct packed {logic [2:0] a; logic [7:0] d; logic [12:0] e;} cdcfg_row_t;
    localparam logic [5:0] VER = 6'h2B; // Arbitrary value
    logic mclk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [2:0] addr_i = 3'h0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] adc_gain_i = 8'h2A;
    logic [7:0] dac_gain_i = 8'h6A;
    logic [7:0] rdata_o;
    logic [4:0] atten, gain;
    logic smute, se, vg, inv, fd, sd, fm, sm, msb, mec;
    logic [3:0] route;
    int fails = 0;
    int check_count = 0;
    int cycles = 0;
    wire logic [12:0] out6;
    wire logic [12:0] out5;
    assign out6 = {se, vg, inv, fd, sd, fm, sm, route, msb, mec};
    assign out5 = {2'h0, atten, gain, smute};
    cdcfg_row_t rows [12] = '{
        '{3'h5, 8'h85, {2'h0, 5'h03, 5'h06, 1'h0}}, '{3'h5, 8'h8A, {2'h0, 5'h06, 5'h0C, 1'h0}},
        '{3'h5, 8'h93, {2'h0, 5'h09, 5'h18, 1'h0}}, '{3'h5, 8'hB8, {2'h0, 5'h00, 5'h00, 1'h1}},
        '{3'h5, 8'h9C, {2'h0, 5'h0C, 5'h00, 1'h0}}, '{3'h5, 8'hA1, {2'h0, 5'h0F, 5'h06, 1'h0}},
        '{3'h5, 8'hAA, {2'h0, 5'h12, 5'h0C, 1'h0}}, '{3'h5, 8'hB3, {2'h0, 5'h15, 5'h18, 1'h0}},
        '{3'h6, 8'h89, 13'h1A04}, '{3'h6, 8'h52, 13'h058A},
        '{3'h6, 8'h3C, 13'h0551}, '{3'h6, 8'hE7, 13'h18E0}};

    cdcfg_bank #(.VERSION_ID(VER)) u_dut (.mclk_i(mclk_i), .resetn_i(resetn_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .adc_gain_i(adc_gain_i),
        .dac_gain_i(dac_gain_i), .sidetone_atten_db_o(atten), .inbuf_gain_db_o(gain),
        .sidetone_mute_o(smute), .single_ended_o(se), .common_vground_o(vg), .common_inverting_o(inv),
        .first_drive_o(fd), .second_drive_o(sd), .first_mute_o(fm), .second_mute_o(sm),
        .adc_route_o(route), .mic_self_bias_o(msb), .mic_ext_cm_o(mec));

    initial forever #20 mclk_i = ~mclk_i;

    // ----------------------------------------
    // Bus and compare tasks
    // ----------------------------------------
    task chk(input string n, input logic [12:0] e, input logic [12:0] g);
        check_count++;
        if (g !== e)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask : wr

    task rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1;
        chk("rdata_o", {5'h00, e}, {5'h00, rdata_o});
    endtask : rd

    task results;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : results

    always @(posedge mclk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 2000)
        begin
            fails++;
            results();
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        repeat (5) @(posedge mclk_i);
        resetn_i <= 1'b1;
        for (int i = 0; i < 12; i++)
        begin
            wr(rows[i].a, rows[i].d);
            repeat (2) @(posedge mclk_i);
            #1;
            chk("decoded", rows[i].e, rows[i].a == 3'h6 ? out6 : out5);
            if (rows[i].a == 3'h6)
                rd(3'h6, rows[i].d);
        end
        $display("test table done");
        @(posedge mclk_i);
        resetn_i <= 1'b0;
        #1;
        chk("reset out5", {2'h0, 5'h00, 5'h00, 1'h1}, out5);
        chk("reset out6", 13'h0404, out6);
        chk("reset rdata_o", 13'h0000, {5'h00, rdata_o});
        repeat (4) @(posedge mclk_i);
        resetn_i <= 1'b1;
        rd(3'h6, 8'h00);
        $display("test reset done");
        wr(3'h5, 8'h9C);
        wr(3'h5, 8'hFF);
        wr(3'h5, 8'h3F);
        wr(3'h2, 8'h55);
        rd(3'h5, adc_gain_i);
        rd(3'h2, 8'h00);
        rd(3'h5, dac_gain_i);
        rd(3'h5, 8'h98);
        rd(3'h5, {2'h3, VER});
        rd(3'h5, adc_gain_i);
        chk("steered out5", {2'h0, 5'h0C, 5'h00, 1'h0}, out5);
        $display("test readback done");
        results();
    end
endmodule : test_codec_sidetone_output_input_config

`default_nettype wire
